// ### src/wws_pkg.sv
// Constants for the windowed watchdog supervisor.
// Assumes a single 40 MHz system clock; durations are given in ns or us and converted to clock cycles, or in timebase ticks.
package wws_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and trigger pulse qualification
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned TRIG_MIN_NS   = 10000;
    localparam int unsigned TRIG_MAX_NS   = 5000000;
    // Least width rounds up, longest width rounds down
    localparam int unsigned TRIG_MIN_CYC  = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TRIG_MAX_CYC  = TRIG_MAX_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // Timebase tick
    localparam int unsigned TICK_US       = 880;
    localparam int unsigned TICK_CYC      = (TICK_US * 1000) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // Durations in timebase ticks
    localparam int unsigned TMR_W         = 11;
    localparam logic [10:0] POR_TICKS     = 11'h00a;
    localparam logic [10:0] SYNC_TICKS    = 11'h1c2;
    localparam logic [10:0] CLOSE_SHORT   = 11'h00f;
    localparam logic [10:0] OPEN_SHORT    = 11'h00a;
    localparam logic [10:0] CLOSE_LONG    = 11'h5dc;
    localparam logic [10:0] OPEN_LONG     = 11'h3e8;
    localparam logic [10:0] PULSE_TICKS   = 11'h004;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values of the pin synchronisers (pull-ups)
    localparam logic        TRIG_RST_VAL  = 1'b1;
    localparam logic        MODE_RST_VAL  = 1'b1;
    localparam logic        DIS_N_RST_VAL = 1'b1;

    typedef enum logic [2:0] {
        WWS_POR,
        WWS_SYNC,
        WWS_CLOSED,
        WWS_OPEN,
        WWS_PULSE,
        WWS_ERR,
        WWS_OFF
    } wws_state_t;

endpackage

// ### src/wws_trig_qual.sv
// Trigger pulse qualifier: measures each low phase of the synchronised trigger.
// Assumes trig_i is already synchronised to clk_i.
module wws_trig_qual
    import wws_pkg::*;
#(
    parameter int unsigned MIN_CYC = TRIG_MIN_CYC,
    parameter int unsigned MAX_CYC = TRIG_MAX_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic en_i,
    input  wire logic trig_i,
    output logic      valid_o,
    output logic      err_o
);
    localparam int unsigned W = $clog2(MAX_CYC + 2);

    logic         prev_q,  prev_d;
    logic [W-1:0] len_q,   len_d;
    logic         valid_q, valid_d;
    logic         err_q,   err_d;

    always_comb begin
        prev_d  = trig_i;
        len_d   = len_q;
        valid_d = 1'b0;
        err_d   = 1'b0;
        if (!trig_i) begin
            if (len_q <= W'(MAX_CYC)) begin
                len_d = len_q + W'(1);
            end
            err_d = (len_q >= W'(MAX_CYC));
        end else begin
            len_d = '0;
            // Rising edge closes a low phase; judge its width
            valid_d = !prev_q && (len_q >= W'(MIN_CYC)) && (len_q <= W'(MAX_CYC));
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_q  <= 1'b1;
            len_q   <= '0;
            valid_q <= 1'b0;
            err_q   <= 1'b0;
        end else if (en_i) begin
            prev_q  <= prev_d;
            len_q   <= len_d;
            valid_q <= valid_d;
            err_q   <= err_d;
        end
    end

    assign valid_o = valid_q;
    assign err_o   = err_q;

    a_valid_width: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && valid_d |-> len_q >= W'(MIN_CYC) && len_q <= W'(MAX_CYC))
        else $error("trigger accepted outside valid width");

endmodule // wws_trig_qual

// ### src/wws_supervisor.sv
// Windowed watchdog supervisor: power-on reset, sync monitoring, closed/open windows.
// Pins pass through two-flop synchronisers; clock enable freezes all state while low.
module wws_supervisor
    import wws_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned TRIG_MIN    = TRIG_MIN_CYC,
    parameter int unsigned TRIG_MAX    = TRIG_MAX_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic en_i,
    input  wire logic trigger_input_i,
    input  wire logic mode_i,
    input  wire logic supervision_disable_n_i,
    output logic      reset_output_n_o
);
    localparam int unsigned PW = $clog2(TICK_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] trig_q,  trig_d;
    logic [1:0] mode_q,  mode_d;
    logic [1:0] dis_n_q, dis_n_d;
    logic       trig_s,  mode_s,  dis_n_s;

    always_comb begin
        trig_d  = {trig_q[0],  trigger_input_i};
        mode_d  = {mode_q[0],  mode_i};
        dis_n_d = {dis_n_q[0], supervision_disable_n_i};
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            trig_q  <= {2{TRIG_RST_VAL}};
            mode_q  <= {2{MODE_RST_VAL}};
            dis_n_q <= {2{DIS_N_RST_VAL}};
        end else if (en_i) begin
            trig_q  <= trig_d;
            mode_q  <= mode_d;
            dis_n_q <= dis_n_d;
        end
    end

    assign trig_s  = trig_q[1];
    assign mode_s  = mode_q[1];
    assign dis_n_s = dis_n_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger qualification
    logic valid;
    logic err;

    wws_trig_qual #(
        .MIN_CYC (TRIG_MIN),
        .MAX_CYC (TRIG_MAX)
    ) u_qual (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .en_i    (en_i),
        .trig_i  (trig_s),
        .valid_o (valid),
        .err_o   (err)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Window state machine with timebase
    function automatic logic expired(input logic [10:0] t, input logic [10:0] n);
        // True on the last tick of a span of n ticks, or later after a mode switch
        return t >= (n - 11'h001);
    endfunction

    wws_state_t  st_q,    st_d;
    logic [10:0] timer_q, timer_d;
    logic [PW-1:0] pre_q, pre_d;
    logic        rout_q,  rout_d;
    logic        tick;
    logic        clear;
    logic [10:0] close_len;
    logic [10:0] open_len;

    assign tick      = (pre_q == PW'(TICK_CYCLES - 1));
    assign close_len = mode_s ? CLOSE_LONG : CLOSE_SHORT;
    assign open_len  = mode_s ? OPEN_LONG  : OPEN_SHORT;

    always_comb begin
        st_d    = st_q;
        clear   = 1'b0;
        pre_d   = tick ? '0 : pre_q + PW'(1);
        timer_d = tick ? timer_q + 11'h001 : timer_q;
        if (st_q == WWS_POR) begin
            if (tick && expired(timer_q, POR_TICKS)) begin
                st_d  = WWS_SYNC;
                clear = 1'b1;
            end
        end else if (!dis_n_s) begin
            st_d  = WWS_OFF;
            clear = 1'b1;
        end else if (err) begin
            st_d  = WWS_ERR;
            clear = 1'b1;
        end else begin
            case (st_q)
                WWS_SYNC: begin
                    if (valid) begin
                        st_d  = WWS_CLOSED;
                        clear = 1'b1;
                    end else if (tick && expired(timer_q, SYNC_TICKS)) begin
                        st_d  = WWS_PULSE;
                        clear = 1'b1;
                    end
                end
                WWS_CLOSED: begin
                    if (valid) begin
                        st_d  = WWS_PULSE;
                        clear = 1'b1;
                    end else if (tick && expired(timer_q, close_len)) begin
                        st_d  = WWS_OPEN;
                        clear = 1'b1;
                    end
                end
                WWS_OPEN: begin
                    if (valid) begin
                        st_d  = WWS_CLOSED;
                        clear = 1'b1;
                    end else if (tick && expired(timer_q, open_len)) begin
                        st_d  = WWS_PULSE;
                        clear = 1'b1;
                    end
                end
                WWS_PULSE: begin
                    if (valid) begin
                        clear = 1'b1;
                    end else if (tick && expired(timer_q, PULSE_TICKS)) begin
                        st_d  = WWS_SYNC;
                        clear = 1'b1;
                    end
                end
                WWS_ERR, WWS_OFF: begin
                    st_d  = WWS_SYNC;
                    clear = 1'b1;
                end
                default: begin
                    st_d  = WWS_SYNC;
                    clear = 1'b1;
                end
            endcase
        end
        if (clear) begin
            timer_d = '0;
            pre_d   = '0;
        end
        rout_d = !(st_d == WWS_POR || st_d == WWS_PULSE || st_d == WWS_ERR);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q    <= WWS_POR;
            timer_q <= '0;
            pre_q   <= '0;
            rout_q  <= 1'b0;
        end else if (en_i) begin
            st_q    <= st_d;
            timer_q <= timer_d;
            pre_q   <= pre_d;
            rout_q  <= rout_d;
        end
    end

    assign reset_output_n_o = rout_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_window_run;
        st_q == WWS_CLOSED && en_i && tick && expired(timer_q, close_len) && !valid;
    endsequence

    sequence s_pulse_end;
        st_q == WWS_PULSE && en_i && tick && timer_q == PULSE_TICKS - 11'h001 && !valid;
    endsequence

    a_por_low: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == WWS_POR |-> !reset_output_n_o)
        else $error("reset released during power-on delay");

    a_sync_start: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && st_q == WWS_SYNC && valid && dis_n_s && !err
        |=> st_q == WWS_CLOSED && timer_q == 11'h000 && reset_output_n_o)
        else $error("valid trigger in sync did not start windows");

    a_sync_expire: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && st_q == WWS_SYNC && tick && timer_q == SYNC_TICKS - 11'h001
        && !valid && dis_n_s && !err |=> st_q == WWS_PULSE && !reset_output_n_o)
        else $error("sync timeout did not issue reset pulse");

    a_closed_open: assert property (@(posedge clk_i) disable iff (rst_i)
        dis_n_s && !err ##0 s_window_run |=> st_q == WWS_OPEN)
        else $error("closed window did not open on time");

    a_closed_trig: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && st_q == WWS_CLOSED && valid && dis_n_s && !err
        |=> st_q == WWS_PULSE ##0 !reset_output_n_o)
        else $error("early trigger did not cause reset");

    a_open_trig: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && st_q == WWS_OPEN && valid && dis_n_s && !err
        |=> st_q == WWS_CLOSED && reset_output_n_o)
        else $error("open window trigger not accepted");

    a_open_expire: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && st_q == WWS_OPEN && tick && expired(timer_q, open_len)
        && !valid && dis_n_s && !err |=> st_q == WWS_PULSE)
        else $error("missed trigger did not cause reset");

    a_pulse_end: assert property (@(posedge clk_i) disable iff (rst_i)
        dis_n_s && !err ##0 s_pulse_end |=> st_q == WWS_SYNC && reset_output_n_o)
        else $error("reset pulse did not end after its width");

    a_pulse_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && st_q == WWS_PULSE && valid && dis_n_s && !err
        |=> st_q == WWS_PULSE && timer_q == 11'h000 && pre_q == '0)
        else $error("trigger during pulse did not restart it");

    a_err_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && err && st_q != WWS_POR && dis_n_s |=> !reset_output_n_o)
        else $error("trigger error did not hold reset low");

    a_off_release: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && !dis_n_s && st_q != WWS_POR |=> reset_output_n_o && st_q == WWS_OFF)
        else $error("disabled supervisor drives reset");

endmodule // wws_supervisor

// ### verification/wws_host_model.sv
// Host controller model: drives trigger pulses and counts the resets it receives.
// Assumes the bench calls pulse() just after a falling clock edge.
module wws_host_model (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    output logic      trig_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int resets_seen = 0;

    // Idle level of the trigger line is high, as with its pull-up
    initial trig_o = 1'b1;

    always @(negedge reset_n_i) begin
        resets_seen++;
    end

    // Low pulse of w clock cycles, then back to idle
    task automatic pulse(input int w);
        trig_o = 1'b0;
        repeat (w) @(negedge clk_i);
        trig_o = 1'b1;
    endtask
endmodule // wws_host_model

// ### verification/tb.sv
// Self-checking bench for the windowed watchdog supervisor.
// Assumes shortened tick and trigger widths; inputs change on falling edges.
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("wrong value at %0t ns: got %0h expected %0h", $time, (g), (e)); \
    end \
end

module tb
    import wws_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TK      = 4;
    localparam int TMIN    = 4;
    localparam int TMAX    = 40;
    localparam int LAT     = 4;
    localparam int POR_C   = int'(POR_TICKS) * TK;
    localparam int SYNC_C  = int'(SYNC_TICKS) * TK;
    localparam int SHORT_C = (int'(CLOSE_SHORT) + int'(OPEN_SHORT)) * TK;
    localparam int LONG_C  = (int'(CLOSE_LONG) + int'(OPEN_LONG)) * TK;
    localparam int PULSE_C = int'(PULSE_TICKS) * TK;

    logic clk_i;
    logic rst_i;
    logic en_i;
    logic mode_i;
    logic dis_n;
    logic trig;
    logic rst_n_o;
    int   fail_count   = 0;
    int   total_checks = 0;

    wws_supervisor #(
        .TICK_CYCLES (TK),
        .TRIG_MIN    (TMIN),
        .TRIG_MAX    (TMAX)
    ) u_dut (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .en_i                    (en_i),
        .trigger_input_i         (trig),
        .mode_i                  (mode_i),
        .supervision_disable_n_i (dis_n),
        .reset_output_n_o        (rst_n_o)
    );

    wws_host_model u_host (
        .clk_i     (clk_i),
        .reset_n_i (rst_n_o),
        .trig_o    (trig)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Cycles until the reset output shows level v, at most lim
    task automatic wait_lvl(input logic v, input int lim, output int n);
        n = 0;
        while (rst_n_o !== v && n < lim) begin
            @(negedge clk_i);
            n++;
        end
    endtask

    // Span matches if within a few cycles of pin synchronisation
    function automatic int fit(input int g, input int e);
        return (g >= e - 3 && g <= e + 3) ? e : g;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Whole run is near 18000 cycles; cut off well past that
    initial begin
        #1000000;
        fail_count++;
        finish_test();
    end

    initial begin
        int n;
        int j;
        int w;
        int r0;
        rst_i  = 1'b1;
        en_i   = 1'b1;
        mode_i = 1'b0;
        dis_n  = 1'b1;
        void'($urandom(96));
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        wait_lvl(1'b1, 100, n);
        `CHK(fit(n, POR_C), POR_C);
        // Too short a pulse must not synchronise
        u_host.pulse(TMIN - 1);
        wait_lvl(1'b0, 3000, n);
        `CHK(fit(n + TMIN - 1, SYNC_C), SYNC_C);
        wait_lvl(1'b1, 100, n);
        `CHK(fit(n, PULSE_C), PULSE_C);
        // Shortest valid pulse, then silence over both short windows
        u_host.pulse(TMIN);
        wait_lvl(1'b0, 500, n);
        `CHK(fit(n, LAT + SHORT_C), LAT + SHORT_C);
        // Clock enable low freezes the pulse count for the frozen cycles
        en_i = 1'b0;
        repeat (10) @(negedge clk_i);
        en_i = 1'b1;
        wait_lvl(1'b1, 100, n);
        `CHK(n, PULSE_C);
        // Longest valid pulse, then random triggers inside open windows
        u_host.pulse(TMAX);
        r0 = u_host.resets_seen;
        for (int i = 0; i < 6; i++) begin
            j = $urandom_range(94, 68);
            w = $urandom_range(38, 6);
            repeat (j - w) @(negedge clk_i);
            u_host.pulse(w);
        end
        `CHK(u_host.resets_seen - r0, 0);
        // Trigger in closed window, then a trigger during the reset pulse
        repeat (20) @(negedge clk_i);
        u_host.pulse(10);
        wait_lvl(1'b0, 20, n);
        `CHK(fit(n, LAT), LAT);
        repeat (2) @(negedge clk_i);
        u_host.pulse(6);
        wait_lvl(1'b1, 100, n);
        `CHK(fit(n, LAT + PULSE_C), LAT + PULSE_C);
        // Long windows
        mode_i = 1'b1;
        u_host.pulse(8);
        wait_lvl(1'b0, 12000, n);
        `CHK(fit(n, LAT + LONG_C), LAT + LONG_C);
        wait_lvl(1'b1, 100, n);
        `CHK(n, PULSE_C);
        // Long to short in mid closed window
        u_host.pulse(8);
        repeat (200) @(negedge clk_i);
        mode_i = 1'b0;
        wait_lvl(1'b0, 200, n);
        `CHK((n >= 36 && n <= 60), 1'b1);
        wait_lvl(1'b1, 100, n);
        `CHK(n, PULSE_C);
        // Short to long in mid closed window
        u_host.pulse(8);
        repeat (20) @(negedge clk_i);
        mode_i = 1'b1;
        wait_lvl(1'b0, 300, n);
        `CHK(n, 300);
        // Disabled supervision never resets; short windows would expire at once otherwise
        dis_n  = 1'b0;
        mode_i = 1'b0;
        r0 = u_host.resets_seen;
        repeat (3000) @(negedge clk_i);
        `CHK(u_host.resets_seen - r0, 0);
        dis_n = 1'b1;
        wait_lvl(1'b0, 2500, n);
        `CHK(fit(n, SYNC_C + 3), SYNC_C + 3);
        wait_lvl(1'b1, 100, n);
        `CHK(n, PULSE_C);
        // Over-long low trigger
        fork
            u_host.pulse(TMAX + 20);
            begin
                repeat (TMAX + 15) @(negedge clk_i);
                `CHK(rst_n_o, 1'b0);
            end
        join
        `CHK(rst_n_o, 1'b0);
        wait_lvl(1'b1, 20, n);
        `CHK(rst_n_o, 1'b1);
        `CHK(n, LAT);
        finish_test();
    end
endmodule // tb
